// >>> hdl/ssp_core.sv
// Execute core for the parameter-flag write, shift-through-carry and
// bit-test-and-skip instructions of a 4-bit controller, with APB access.
// Assumes an APB master on pclk; one instruction is run per INSTR write.
//
// Notes on behaviour
// [RULE_01] The parameter-flag write is known by its fixed leading pattern, carries four immediate bits and takes one cycle.
// [RULE_02] Immediate bits 0 to 2 of the parameter-flag write are reserved and steer nothing.
// [RULE_03] Immediate bit 3 set selects the oscillator divided by 16384 as the watchdog clock.
// [RULE_04] Shift left moves the nibble up, old bit 3 into carry, zero into bit 0, result to memory and accumulator.
// [RULE_05] Shift left is decoded from its nine-bit pattern and a seven-bit memory address.
// [RULE_06] Shift right moves the nibble down, old bit 0 into carry, zero into bit 3, result to memory and accumulator.
// [RULE_07] Shift right is decoded from its own nine-bit pattern and address and takes one cycle.
// [RULE_08] Bit-0 test adds two to the program counter when bit 0 is one, else one.
// [RULE_09] Bit-0 test is decoded from its nine-bit pattern and address and takes one cycle.
// [RULE_10] Bit-1 test adds two to the program counter when bit 1 is one, else one.
// [RULE_11] Bit-1 test is decoded from its nine-bit pattern and address and takes one cycle.
// [RULE_12] Bit-2 test adds two to the program counter when bit 2 is one, else one, in one cycle.
// [RULE_13] Both shifts set the zero flag on a zero result and clear it otherwise, each in one cycle.
// [RULE_14] The tests change only the program counter, never carry, zero, accumulator or memory.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "ssp_consts.svh"

module ssp_core import ssp_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Watchdog prescaler select
    output logic wdt_div_sel
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'h0};
        reg_hit = (w == `SSP_OFS_INSTR) || (w == `SSP_OFS_PC) ||
                  (w == `SSP_OFS_FLAGS) || (w == `SSP_OFS_PARAM) ||
                  (w == `SSP_OFS_MEMADDR) || (w == `SSP_OFS_MEMDATA) ||
                  (w == `SSP_OFS_STATUS) || (w == `SSP_OFS_COUNT);
    endfunction : reg_hit

    function automatic ssp_pc_t pc_step(input ssp_pc_t pc, input logic skip);
        pc_step = skip ? pc + 11'h002 : pc + 11'h001;
    endfunction : pc_step

    function automatic logic [15:0] count_step(input logic [15:0] c);
        count_step = (c == 16'hFFFF) ? c : c + 16'h0001;
    endfunction : count_step

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic pready_r;
    logic pready_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [15:0] instr_r;
    logic [15:0] instr_nxt;
    logic exec_r;
    logic exec_nxt;
    ssp_pc_t program_counter_r;
    ssp_pc_t program_counter_nxt;
    ssp_nibble_t accumulator_r;
    ssp_nibble_t accumulator_nxt;
    logic carry_flag_r;
    logic carry_flag_nxt;
    logic zero_flag_r;
    logic zero_flag_nxt;
    ssp_nibble_t parameter_flags_r;
    ssp_nibble_t parameter_flags_nxt;
    logic wdt_div_sel_r;
    logic wdt_div_sel_nxt;
    logic [6:0] mem_addr_r;
    logic [6:0] mem_addr_nxt;
    ssp_nibble_t mem_r [0:127];
    ssp_nibble_t mem_nxt [0:127];
    logic illegal_r;
    logic illegal_nxt;
    logic skip_r;
    logic skip_nxt;
    logic [15:0] exec_cnt_r;
    logic [15:0] exec_cnt_nxt;
    logic [15:0] skip_cnt_r;
    logic [15:0] skip_cnt_nxt;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    ssp_op_t op;
    logic [6:0] op_addr;
    logic [3:0] op_imm;
    ssp_nibble_t operand;
    logic [7:0] word_addr;
    logic access_first;
    logic commit_wr;

    ssp_decode u_decode (
        .instr(instr_r),
        .op(op),
        .mem_addr(op_addr),
        .imm(op_imm)
    );

    assign operand = mem_r[op_addr];
    assign word_addr = {paddr[7:2], 2'h0};
    assign access_first = psel & penable & ~pready_r;
    assign commit_wr = psel & penable & pready_r & pwrite & reg_hit(paddr);

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    always_comb begin
        pready_nxt = access_first;
        pslverr_nxt = 1'b0;
        prdata_nxt = 32'h0000_0000;
        if (access_first) begin
            pslverr_nxt = ~reg_hit(paddr);
            if (!pwrite) begin
                unique case (word_addr)
                    `SSP_OFS_INSTR: prdata_nxt = {16'h0000, instr_r};
                    `SSP_OFS_PC: prdata_nxt = {21'h000000, program_counter_r};
                    `SSP_OFS_FLAGS: prdata_nxt = {26'h0000000, zero_flag_r,
                                                  carry_flag_r, accumulator_r};
                    `SSP_OFS_PARAM: prdata_nxt = {27'h0000000, wdt_div_sel_r,
                                                  parameter_flags_r};
                    `SSP_OFS_MEMADDR: prdata_nxt = {25'h0000000, mem_addr_r};
                    `SSP_OFS_MEMDATA: prdata_nxt = {28'h0000000, mem_r[mem_addr_r]};
                    `SSP_OFS_STATUS: prdata_nxt = {29'h00000000, skip_r, illegal_r,
                                                   exec_r};
                    `SSP_OFS_COUNT: prdata_nxt = {skip_cnt_r, exec_cnt_r};
                    default: prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;

    // ------------------------------------------------------------
    // Instruction execute
    // ------------------------------------------------------------
    always_comb begin
        ssp_nibble_t res;
        logic skip;
        res = 4'h0;
        skip = 1'b0;
        instr_nxt = instr_r;
        exec_nxt = 1'b0;
        program_counter_nxt = program_counter_r;
        accumulator_nxt = accumulator_r;
        carry_flag_nxt = carry_flag_r;
        zero_flag_nxt = zero_flag_r;
        parameter_flags_nxt = parameter_flags_r;
        wdt_div_sel_nxt = wdt_div_sel_r;
        mem_addr_nxt = mem_addr_r;
        illegal_nxt = illegal_r;
        skip_nxt = skip_r;
        exec_cnt_nxt = exec_cnt_r;
        skip_cnt_nxt = skip_cnt_r;
        for (int i = 0; i < 128; i++) begin
            mem_nxt[i] = mem_r[i];
        end

        // Software writes land at the completing access edge.
        if (commit_wr) begin
            unique case (word_addr)
                `SSP_OFS_INSTR: begin
                    instr_nxt = pwdata[15:0];
                    exec_nxt = 1'b1;
                end
                `SSP_OFS_PC: program_counter_nxt = pwdata[10:0];
                `SSP_OFS_FLAGS: begin
                    accumulator_nxt = pwdata[3:0];
                    carry_flag_nxt = pwdata[`SSP_FLAGS_CF_BIT];
                    zero_flag_nxt = pwdata[`SSP_FLAGS_ZF_BIT];
                end
                `SSP_OFS_MEMADDR: mem_addr_nxt = pwdata[6:0];
                `SSP_OFS_MEMDATA: mem_nxt[mem_addr_r] = pwdata[3:0];
                `SSP_OFS_STATUS: begin
                    if (pwdata[`SSP_STAT_ILLEGAL_BIT]) begin
                        illegal_nxt = 1'b0;
                    end
                end
                `SSP_OFS_COUNT: begin
                    exec_cnt_nxt = 16'h0000;
                    skip_cnt_nxt = 16'h0000;
                end
                default: begin
                end
            endcase
        end

        // One machine cycle per instruction, the cycle after the write.
        if (exec_r) begin
            exec_cnt_nxt = count_step(exec_cnt_r);
            unique case (op)
                SSP_OP_PMF: begin
                    parameter_flags_nxt = op_imm; // [RULE_01]
                    // Only bit 3 steers logic; bits 0 to 2 are kept and read back.
                    wdt_div_sel_nxt = op_imm[`SSP_PARAM_WDT_BIT]; // [RULE_02] [RULE_03]
                    program_counter_nxt = pc_step(program_counter_r, 1'b0);
                end
                SSP_OP_SHL: begin
                    res = {operand[2:0], 1'b0}; // [RULE_04]
                    carry_flag_nxt = operand[3]; // [RULE_04]
                    zero_flag_nxt = (res == 4'h0); // [RULE_13]
                    accumulator_nxt = res; // [RULE_04]
                    mem_nxt[op_addr] = res; // [RULE_04]
                    program_counter_nxt = pc_step(program_counter_r, 1'b0); // [RULE_13]
                end
                SSP_OP_SHR: begin
                    res = {1'b0, operand[3:1]}; // [RULE_06]
                    carry_flag_nxt = operand[0]; // [RULE_06]
                    zero_flag_nxt = (res == 4'h0); // [RULE_13]
                    accumulator_nxt = res; // [RULE_06]
                    mem_nxt[op_addr] = res; // [RULE_06]
                    program_counter_nxt = pc_step(program_counter_r, 1'b0); // [RULE_07]
                end
                SSP_OP_SKIP_IF_BIT_ZERO_SET_OP, SSP_OP_SKIP_IF_BIT_ONE_SET_OP, SSP_OP_SKIP_IF_BIT_TWO_SET_OP: begin
                    if (op == SSP_OP_SKIP_IF_BIT_ZERO_SET_OP) begin
                        skip = operand[0]; // [RULE_08] [RULE_09]
                    end else if (op == SSP_OP_SKIP_IF_BIT_ONE_SET_OP) begin
                        skip = operand[1]; // [RULE_10] [RULE_11]
                    end else begin
                        skip = operand[2]; // [RULE_12]
                    end
                    // Flags, accumulator and memory keep their values here.
                    program_counter_nxt = pc_step(program_counter_r, skip); // [RULE_14]
                    skip_nxt = skip;
                    if (skip) begin
                        skip_cnt_nxt = count_step(skip_cnt_r);
                    end
                end
                SSP_OP_NONE: begin
                    // Unknown words still advance the counter by one.
                    illegal_nxt = 1'b1;
                    program_counter_nxt = pc_step(program_counter_r, 1'b0);
                end
                default: begin
                    illegal_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r <= 16'h0000;
            exec_r <= 1'b0;
            program_counter_r <= `SSP_RST_PC;
            accumulator_r <= `SSP_RST_ACC;
            carry_flag_r <= 1'b0;
            zero_flag_r <= 1'b0;
            parameter_flags_r <= `SSP_RST_PARAM;
            wdt_div_sel_r <= 1'b0;
            mem_addr_r <= `SSP_RST_MEMADDR;
            illegal_r <= 1'b0;
            skip_r <= 1'b0;
            exec_cnt_r <= 16'h0000;
            skip_cnt_r <= 16'h0000;
        end else begin
            instr_r <= instr_nxt;
            exec_r <= exec_nxt;
            program_counter_r <= program_counter_nxt;
            accumulator_r <= accumulator_nxt;
            carry_flag_r <= carry_flag_nxt;
            zero_flag_r <= zero_flag_nxt;
            parameter_flags_r <= parameter_flags_nxt;
            wdt_div_sel_r <= wdt_div_sel_nxt;
            mem_addr_r <= mem_addr_nxt;
            illegal_r <= illegal_nxt;
            skip_r <= skip_nxt;
            exec_cnt_r <= exec_cnt_nxt;
            skip_cnt_r <= skip_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 128; i++) begin
                mem_r[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < 128; i++) begin
                mem_r[i] <= mem_nxt[i];
            end
        end
    end

    assign wdt_div_sel = wdt_div_sel_r;

endmodule : ssp_core

// >>> hdl/ssp_consts.svh
// Constants for the shift, skip and parameter-flag execute block.
// Assumes inclusion by bare name from the core module, the decoder and the bench.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SSP_OFS_INSTR 8'h00
`define SSP_OFS_PC 8'h04
`define SSP_OFS_FLAGS 8'h08
`define SSP_OFS_PARAM 8'h0C
`define SSP_OFS_MEMADDR 8'h10
`define SSP_OFS_MEMDATA 8'h14
`define SSP_OFS_STATUS 8'h18
`define SSP_OFS_COUNT 8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSP_FLAGS_CF_BIT 4
`define SSP_FLAGS_ZF_BIT 5
`define SSP_PARAM_WDT_BIT 3
`define SSP_STAT_BUSY_BIT 0
`define SSP_STAT_ILLEGAL_BIT 1
`define SSP_STAT_SKIP_BIT 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SSP_RST_PC 11'h000
`define SSP_RST_ACC 4'h0
`define SSP_RST_PARAM 4'h0
`define SSP_RST_MEMADDR 7'h00

// ----------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------
`define SSP_PAT_PMF 11'h0B0
`define SSP_PAT_SHL 9'h098
`define SSP_PAT_SHR 9'h09A
`define SSP_PAT_SKIP_IF_BIT_ZERO_SET_OP 9'h110
`define SSP_PAT_SKIP_IF_BIT_ONE_SET_OP 9'h113
`define SSP_PAT_SKIP_IF_BIT_TWO_SET_OP 9'h112

`endif

// >>> hdl/ssp_pkg.sv
// Types shared by the decoder and the execute core.
// Assumes the constants header sits beside it.
package ssp_pkg;

    // ------------------------------------------------------------
    // Decoded operation
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SSP_OP_NONE = 3'h0,
        SSP_OP_PMF = 3'h1,
        SSP_OP_SHL = 3'h2,
        SSP_OP_SHR = 3'h3,
        SSP_OP_SKIP_IF_BIT_ZERO_SET_OP = 3'h4,
        SSP_OP_SKIP_IF_BIT_ONE_SET_OP = 3'h5,
        SSP_OP_SKIP_IF_BIT_TWO_SET_OP = 3'h6
    } ssp_op_t;

    typedef logic [3:0] ssp_nibble_t;
    typedef logic [10:0] ssp_pc_t;

endpackage : ssp_pkg

// >>> hdl/ssp_decode.sv
// Combinational instruction decoder for the shift, skip and parameter ops.
// Assumes a stable 16-bit instruction word at its input.
`timescale 1ns/1ps
`include "ssp_consts.svh"

module ssp_decode import ssp_pkg::*; (
    // Instruction word
    input wire logic [15:0] instr,
    // Decoded fields
    output ssp_op_t op,
    output logic [6:0] mem_addr,
    output logic [3:0] imm
);

    // ------------------------------------------------------------
    // Pattern match
    // ------------------------------------------------------------
    always_comb begin
        mem_addr = instr[6:0];
        imm = instr[3:0];
        op = SSP_OP_NONE;
        if (instr[15:5] == `SSP_PAT_PMF) begin
            op = SSP_OP_PMF; // [RULE_01]
        end else if (instr[15:7] == `SSP_PAT_SHL) begin
            op = SSP_OP_SHL; // [RULE_05]
        end else if (instr[15:7] == `SSP_PAT_SHR) begin
            op = SSP_OP_SHR; // [RULE_07]
        end else if (instr[15:7] == `SSP_PAT_SKIP_IF_BIT_ZERO_SET_OP) begin
            op = SSP_OP_SKIP_IF_BIT_ZERO_SET_OP; // [RULE_09]
        end else if (instr[15:7] == `SSP_PAT_SKIP_IF_BIT_ONE_SET_OP) begin
            op = SSP_OP_SKIP_IF_BIT_ONE_SET_OP; // [RULE_11]
        end else if (instr[15:7] == `SSP_PAT_SKIP_IF_BIT_TWO_SET_OP) begin
            op = SSP_OP_SKIP_IF_BIT_TWO_SET_OP; // [RULE_12]
        end
    end

endmodule : ssp_decode

// >>> test/ssp_chk.sv
// Checker for the execute core: APB timing and watchdog select.
// Assumes it is bound to ssp_core and sees only its ports.
`timescale 1ns/1ps

module ssp_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Watchdog select
    input wire logic wdt_div_sel
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic done;
    logic pmf_wr;
    assign done = psel && penable && pready;
    assign pmf_wr = done && pwrite && paddr[7:2] == 6'h00 && pwdata[15:5] == 11'h0B0;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_WDT_SET: assert property (pmf_wr && pwdata[3] |-> ##2 wdt_div_sel)
        else $error("watchdog select not set by parameter write");
    AST_WDT_CLR: assert property (pmf_wr && !pwdata[3] |-> ##2 !wdt_div_sel)
        else $error("watchdog select set by reserved bits");
    AST_WDT_HOLD: assert property ($changed(wdt_div_sel) |-> $past(pmf_wr, 2))
        else $error("watchdog select changed without parameter write");
    AST_PARAM_RD: assert property (done && !pwrite && paddr == 8'h0C |->
        prdata[4] == wdt_div_sel)
        else $error("parameter readback disagrees with watchdog select");
    AST_WAIT_STATE: assert property ((psel && !penable) ##1 (psel && penable) |->
        !pready ##1 pready)
        else $error("access phase did not take one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_RDATA_IDLE: assert property (!pready || pwrite |-> prdata == 32'h0)
        else $error("read data not zero outside a read answer");
    AST_ERR_MAP: assert property (done |-> pslverr == (paddr[7:5] != 3'h0))
        else $error("slave error does not match address map");

    CV_PMF: cover property (pmf_wr ##2 wdt_div_sel);
    CV_ERR: cover property (done && pslverr);
    CV_READ: cover property (done && !pwrite);
endmodule : ssp_chk

bind ssp_core ssp_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .wdt_div_sel(wdt_div_sel));

// >>> test/shift_skip_param_decode_tb.sv
// Self-checking bench for the shift, skip and parameter-flag core.
// Assumes the core's APB register map and one-wait-state answer.
`timescale 1ns/1ps
`include "ssp_consts.svh"

module shift_skip_param_decode_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wdt_div_sel, err, b4;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] m, imm;
    logic [6:0] a;
    logic [10:0] pc;
    logic [5:0] fl;
    logic [4:0] par;
    logic [15:0] ins;
    logic [21:0] e;
    int n_mismatch, num_checks, cyc, op, n_exec, n_skip;

    ssp_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .wdt_div_sel(wdt_div_sel));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Tasks and models
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(what, exp, rd);
    endtask : rdchk

    // Result word: next counter, zero, carry, accumulator, nibble, skip taken.
    function automatic logic [21:0] exp_step(input int o, input logic [3:0] v,
        input logic [10:0] p, input logic [5:0] f);
        logic [3:0] r;
        logic sk;
        r = (o == 1) ? {v[2:0], 1'b0} : {1'b0, v[3:1]};
        sk = (o >= 3) ? v[o - 3] : 1'b0;
        if (o == 1 || o == 2)
            return {p + 11'h001, r == 4'h0, (o == 1) ? v[3] : v[0], r, r, 1'b0};
        return {p + (sk ? 11'h002 : 11'h001), f, v, sk};
    endfunction : exp_step

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        cyc = 0;
        n_exec = 0;
        n_skip = 0;
        par = 5'h00;
        void'($urandom(69511));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 32; i += 4) rdchk("reset value", i[7:0], 32'h0);
        chk("wdt reset", 32'h0, {31'h0, wdt_div_sel});
        $display("test reset done");
        apb(1'b1, 8'h20, 32'h5);
        chk("unmapped write err", 32'h1, {31'h0, err});
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped read err", 32'h1, {31'h0, err});
        chk("unmapped read data", 32'h0, rd);
        $display("test unmapped done");
        for (int i = 0; i < 60; i++) begin
            op = i % 6;
            m = (i < 24) ? i[3:0] : 4'($urandom);
            a = 7'($urandom);
            pc = (i == 8) ? 11'h7FF : (i == 9) ? 11'h7FE : 11'($urandom);
            fl = 6'($urandom);
            imm = 4'($urandom);
            b4 = 1'($urandom);
            apb(1'b1, `SSP_OFS_MEMADDR, {25'h0, a});
            apb(1'b1, `SSP_OFS_MEMDATA, {28'h0, m});
            apb(1'b1, `SSP_OFS_PC, {21'h0, pc});
            apb(1'b1, `SSP_OFS_FLAGS, {26'h0, fl});
            case (op)
                0: ins = {`SSP_PAT_PMF, b4, imm};
                1: ins = {`SSP_PAT_SHL, a};
                2: ins = {`SSP_PAT_SHR, a};
                3: ins = {`SSP_PAT_SKIP_IF_BIT_ZERO_SET_OP, a};
                4: ins = {`SSP_PAT_SKIP_IF_BIT_ONE_SET_OP, a};
                default: ins = {`SSP_PAT_SKIP_IF_BIT_TWO_SET_OP, a};
            endcase
            e = exp_step(op, m, pc, fl);
            if (op == 0) begin
                par = {imm[3], imm};
            end
            n_exec++;
            n_skip += e[0];
            apb(1'b1, `SSP_OFS_INSTR, {16'h0, ins});
            rdchk("pc", `SSP_OFS_PC, {21'h0, e[21:11]});
            rdchk("flags", `SSP_OFS_FLAGS, {26'h0, e[10:5]});
            rdchk("nibble", `SSP_OFS_MEMDATA, {28'h0, e[4:1]});
            rdchk("param", `SSP_OFS_PARAM, {27'h0, par});
            chk("wdt select", {31'h0, par[4]}, {31'h0, wdt_div_sel});
            if (op >= 3) begin
                rdchk("status", `SSP_OFS_STATUS, {29'h0, e[0], 2'b00});
            end
        end
        rdchk("count", `SSP_OFS_COUNT, {n_skip[15:0], n_exec[15:0]});
        $display("test ops done");
        apb(1'b1, `SSP_OFS_PC, 32'h0000_0123);
        apb(1'b1, `SSP_OFS_INSTR, 32'h0000_FFFF);
        rdchk("unknown pc", `SSP_OFS_PC, 32'h0000_0124);
        apb(1'b0, `SSP_OFS_STATUS, 32'h0);
        chk("illegal set", 32'h1, {31'h0, rd[1]});
        apb(1'b1, `SSP_OFS_STATUS, 32'h0000_0002);
        apb(1'b0, `SSP_OFS_STATUS, 32'h0);
        chk("illegal clear", 32'h0, {31'h0, rd[1]});
        apb(1'b1, `SSP_OFS_COUNT, 32'h0);
        rdchk("count clear", `SSP_OFS_COUNT, 32'h0);
        $display("test unknown done");
        end_of_test();
    end
endmodule : shift_skip_param_decode_tb
